// File: inc/phy_mgmt_pkg.sv
/*
 * constants, codes and state layout for the phy management access and
 * pause flow-control register block.
 * assumes a 100 MHz REF_CLK and a 12-bit apb byte address.
 */
package phy_mgmt_pkg;

    // clock and management clock timing
    localparam int unsigned REF_CLK_MHZ   = 100;
    localparam int unsigned MDC_PERIOD_NS = 400;
    localparam int unsigned MDC_HALF_CYC  = (MDC_PERIOD_NS * REF_CLK_MHZ + 1999) / 2000;
    localparam logic [7:0]  MDC_HALF_M1   = 8'(MDC_HALF_CYC - 1);

    // register indices and byte addresses
    localparam int unsigned  REG_IDX_ACCESS = 6;
    localparam int unsigned  REG_IDX_DATA   = 7;
    localparam int unsigned  REG_IDX_FLOW   = 8;
    localparam logic [11:0]  ADDR_ACCESS    = 12'(REG_IDX_ACCESS * 4);
    localparam logic [11:0]  ADDR_DATA      = 12'(REG_IDX_DATA * 4);
    localparam logic [11:0]  ADDR_FLOW      = 12'(REG_IDX_FLOW * 4);

    // field positions
    localparam int unsigned ACC_PHY_LSB    = 11;
    localparam int unsigned ACC_REG_LSB    = 6;
    localparam int unsigned ACC_WRITE_BIT  = 1;
    localparam int unsigned ACC_BUSY_BIT   = 0;
    localparam int unsigned FLOW_PT_LSB    = 16;
    localparam int unsigned FLOW_PASS_BIT  = 2;
    localparam int unsigned FLOW_RXEN_BIT  = 1;
    localparam int unsigned FLOW_BUSY_BIT  = 0;

    // reset values
    localparam logic [31:0] ACCESS_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET   = 32'h0000_0000;
    localparam logic [31:0] FLOW_RESET   = 32'h0000_0000;
    localparam logic [4:0]  INTERNAL_PHY_ADDR = 5'h01;

    // management frame layout, bit 0 is the first preamble bit
    localparam logic [5:0]  FRAME_LAST_BIT = 6'h3f;
    localparam logic [5:0]  FRAME_TA_BIT   = 6'h2e;
    localparam logic [5:0]  FRAME_DATA_BIT = 6'h30;
    localparam logic [31:0] FRAME_PREAMBLE = 32'hffff_ffff;
    localparam logic [1:0]  FRAME_START    = 2'h1;
    localparam logic [1:0]  FRAME_OP_WR    = 2'h1;
    localparam logic [1:0]  FRAME_OP_RD    = 2'h2;
    localparam logic [1:0]  FRAME_TA_WR    = 2'h2;
    localparam logic [1:0]  FRAME_TA_RD    = 2'h3;

    typedef enum logic [2:0] {
        MD_IDLE = 3'b001,
        MD_RUN  = 3'b010,
        MD_END  = 3'b100
    } md_state_e;

    // the whole state of the block
    typedef struct packed {
        md_state_e   md_state;
        logic [7:0]  div_cnt;
        logic        mdc;
        logic        mdio_o;
        logic        mdio_oe_n;
        logic        mdio_s1;
        logic        mdio_s2;
        logic [5:0]  bit_cnt;
        logic [63:0] shift;
        logic [4:0]  phy_addr;
        logic [4:0]  reg_idx;
        logic        write_not_read;
        logic        access_busy;
        logic [15:0] mgmt_data;
        logic [15:0] pause_time;
        logic        pass_ctrl;
        logic        rx_pause_en;
        logic        pause_pend;
        logic [15:0] halt_cnt;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_s;

endpackage : phy_mgmt_pkg

// File: core/phy_mgmt_flow.sv
/*
 * apb register block for phy management cycles and pause flow control.
 * drives one management frame per access on MDC/MDIO, keeps the pause
 * time and busy flag for the transmitter, and counts received pause time.
 * assumes the mac-side strobes run on REF_CLK; MDIO_I is asynchronous.
 */
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1: phy address field selects target phy
// RQ2: register index field selects phy register
// RQ3: direction bit: set writes, clear reads
// RQ4: software sets busy to start cycle
// RQ5: software waits busy clear before writing
// RQ6: busy held until access finishes
// RQ7: write data held by software until done
// RQ8: read data valid only after busy clears
// RQ9: data register low sixteen bits used
// RQ10: pause time from flow register upper half
// RQ11: pause frame fields follow standard format
// RQ12: full duplex busy until pause sent
// RQ13: half duplex busy during back pressure
// RQ14: software checks flow busy before writing
// RQ15: transmitter disabled: no pause, no backpressure
// RQ16: flow enable acts on receive side only
// RQ17: pass control bit never gates delivery
// RQ18: software loads pause time before enabling
// RQ19: pause send trigger comes from elsewhere
// RQ20: received pause halts transmitter for quanta
// RQ21: software writes zero to flow busy
// RQ22: busy launches one clause-22 frame
// RQ23: reserved bits read zero, writes ignored
module phy_mgmt_flow
    import phy_mgmt_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // management link
    output logic             MDC,
    output logic             MDIO_O,
    output logic             MDIO_OE_N,
    input  wire logic        MDIO_I,
    // mac transmit side
    input  wire logic        TX_ENABLE,
    input  wire logic        FULL_DUPLEX,
    input  wire logic        PAUSE_REQ,
    input  wire logic        PAUSE_SENT,
    input  wire logic        BACKPRESSURE_REQ,
    output logic             PAUSE_SEND,
    output logic [15:0]      PAUSE_TIME,
    output logic             BACKPRESSURE,
    // mac receive side
    input  wire logic        RX_PAUSE_VALID,
    input  wire logic [15:0] RX_PAUSE_QUANTA,
    input  wire logic        SLOT_TICK,
    output logic             TX_HALT,
    output logic             RX_PASS_CTRL
);

    state_s q;
    state_s d;

    logic        bus_access;
    logic        bus_commit;
    logic        bp_active;
    logic        flow_busy;
    logic        mdc_tick;
    logic        mdc_rise;
    logic        mdc_fall;
    logic [1:0]  frame_op;
    logic [1:0]  frame_ta;
    logic [15:0] frame_data;

    // apb phases: first access cycle latches the answer, second completes
    assign bus_access = PSEL & PENABLE & ~q.pready;
    assign bus_commit = PSEL & PENABLE & q.pready;

    // back pressure only in half duplex with the transmitter on
    assign bp_active = BACKPRESSURE_REQ & TX_ENABLE & ~FULL_DUPLEX;   // RQ15
    assign flow_busy = q.pause_pend | bp_active;                      // RQ12 RQ13

    // management clock divider events
    assign mdc_tick = (q.div_cnt == MDC_HALF_M1);
    assign mdc_rise = mdc_tick & ~q.mdc;
    assign mdc_fall = mdc_tick & q.mdc;

    // frame fields from the programmed direction
    assign frame_op   = q.write_not_read ? FRAME_OP_WR : FRAME_OP_RD;   // RQ3
    assign frame_ta   = q.write_not_read ? FRAME_TA_WR : FRAME_TA_RD;
    assign frame_data = q.write_not_read ? q.mgmt_data : 16'hffff;

    // next state of everything
    always_comb
    begin
        d = q;

        // two-flop synchroniser for the shared data pin
        d.mdio_s1 = MDIO_I;
        d.mdio_s2 = q.mdio_s1;

        // apb read answer and error for unmapped addresses
        d.pready = bus_access;
        if (bus_access)
        begin
            d.pslverr = 1'b0;
            d.prdata  = 32'h0000_0000;                                  // RQ23
            if (PADDR == ADDR_ACCESS)
            begin
                d.prdata[ACC_PHY_LSB +: 5]  = q.phy_addr;             // RQ1
                d.prdata[ACC_REG_LSB +: 5]  = q.reg_idx;              // RQ2
                d.prdata[ACC_WRITE_BIT]     = q.write_not_read;
                d.prdata[ACC_BUSY_BIT]      = q.access_busy;          // RQ6
            end
            else if (PADDR == ADDR_DATA)
            begin
                d.prdata[15:0] = q.mgmt_data;                         // RQ9 RQ8
            end
            else if (PADDR == ADDR_FLOW)
            begin
                d.prdata[FLOW_PT_LSB +: 16] = q.pause_time;
                d.prdata[FLOW_PASS_BIT]     = q.pass_ctrl;
                d.prdata[FLOW_RXEN_BIT]     = q.rx_pause_en;
                d.prdata[FLOW_BUSY_BIT]     = flow_busy;              // RQ12 RQ13
            end
            else
            begin
                d.pslverr = 1'b1;
            end
        end
        else if (!PSEL)
        begin
            d.pslverr = 1'b0;
        end

        // apb writes take effect at the completing edge
        if (bus_commit && PWRITE)
        begin
            if (PADDR == ADDR_ACCESS && !q.access_busy)
            begin
                d.phy_addr       = PWDATA[ACC_PHY_LSB +: 5];          // RQ1
                d.reg_idx        = PWDATA[ACC_REG_LSB +: 5];          // RQ2
                d.write_not_read = PWDATA[ACC_WRITE_BIT];             // RQ3
                d.access_busy    = PWDATA[ACC_BUSY_BIT];              // RQ4 RQ22
            end
            else if (PADDR == ADDR_DATA && !q.access_busy)
            begin
                d.mgmt_data = PWDATA[15:0];                           // RQ9 RQ7
            end
            else if (PADDR == ADDR_FLOW)
            begin
                d.pause_time  = PWDATA[FLOW_PT_LSB +: 16];            // RQ10 RQ18
                d.pass_ctrl   = PWDATA[FLOW_PASS_BIT];                // RQ17
                d.rx_pause_en = PWDATA[FLOW_RXEN_BIT];                // RQ16
            end
        end

        // management frame engine
        case (q.md_state)
            MD_IDLE:
            begin
                d.div_cnt   = 8'h00;
                d.mdc       = 1'b0;
                d.mdio_oe_n = 1'b1;
                d.mdio_o    = 1'b1;
                if (q.access_busy)
                begin
                    // preamble, start, op, address, index, turnaround, data
                    d.shift = {FRAME_PREAMBLE, FRAME_START, frame_op,
                               q.phy_addr, q.reg_idx, frame_ta, frame_data}; // RQ22
                    d.bit_cnt   = 6'h00;
                    d.mdio_o    = 1'b1;
                    d.mdio_oe_n = 1'b0;
                    d.md_state  = MD_RUN;
                end
            end
            MD_RUN:
            begin
                d.div_cnt = mdc_tick ? 8'h00 : q.div_cnt + 8'h01;
                if (mdc_tick)
                begin
                    d.mdc = ~q.mdc;
                end
                // read data is sampled on the rising edge
                if (mdc_rise && !q.write_not_read && q.bit_cnt >= FRAME_DATA_BIT)
                begin
                    d.mgmt_data = {q.mgmt_data[14:0], q.mdio_s2};     // RQ3
                end
                // next bit is driven on the falling edge
                if (mdc_fall)
                begin
                    if (q.bit_cnt == FRAME_LAST_BIT)
                    begin
                        d.mdio_oe_n = 1'b1;
                        d.md_state  = MD_END;
                    end
                    else
                    begin
                        d.bit_cnt = q.bit_cnt + 6'h01;
                        d.shift   = {q.shift[62:0], 1'b1};
                        d.mdio_o  = q.shift[62];
                        // release the pin from turnaround on a read
                        d.mdio_oe_n = ~q.write_not_read &&
                                      (q.bit_cnt + 6'h01 >= FRAME_TA_BIT);
                    end
                end
            end
            MD_END:
            begin
                d.access_busy = 1'b0;                                 // RQ6 RQ8
                d.md_state    = MD_IDLE;
            end
            default:
            begin
                d.md_state = MD_IDLE;
            end
        endcase

        // full-duplex pause request held until the frame is on the wire
        if (PAUSE_SENT)
        begin
            d.pause_pend = 1'b0;                                      // RQ12
        end
        if (PAUSE_REQ && FULL_DUPLEX && TX_ENABLE)
        begin
            d.pause_pend = 1'b1;                                      // RQ12 RQ19
        end
        if (!TX_ENABLE)
        begin
            d.pause_pend = 1'b0;                                      // RQ15
        end

        // received pause: load quanta, count down per slot time
        if (q.halt_cnt != 16'h0000 && SLOT_TICK)
        begin
            d.halt_cnt = q.halt_cnt - 16'h0001;                       // RQ20
        end
        if (RX_PAUSE_VALID && q.rx_pause_en && FULL_DUPLEX)
        begin
            d.halt_cnt = RX_PAUSE_QUANTA;                             // RQ16 RQ20
        end
    end

    // single register for the whole state
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            q                <= '0;
            q.md_state       <= MD_IDLE;
            q.mdio_o         <= 1'b1;
            q.mdio_oe_n      <= 1'b1;
            q.mdio_s1        <= 1'b1;
            q.mdio_s2        <= 1'b1;
            q.phy_addr       <= ACCESS_RESET[ACC_PHY_LSB +: 5];
            q.reg_idx        <= ACCESS_RESET[ACC_REG_LSB +: 5];
            q.write_not_read <= ACCESS_RESET[ACC_WRITE_BIT];
            q.access_busy    <= ACCESS_RESET[ACC_BUSY_BIT];
            q.mgmt_data      <= DATA_RESET[15:0];
            q.pause_time     <= FLOW_RESET[FLOW_PT_LSB +: 16];
            q.pass_ctrl      <= FLOW_RESET[FLOW_PASS_BIT];
            q.rx_pause_en    <= FLOW_RESET[FLOW_RXEN_BIT];
        end
        else
        begin
            q <= d;
        end
    end

    // outputs
    assign PRDATA       = q.prdata;
    assign PREADY       = q.pready;
    assign PSLVERR      = q.pslverr & q.pready;
    assign MDC          = q.mdc;
    assign MDIO_O       = q.mdio_o;
    assign MDIO_OE_N    = q.mdio_oe_n;
    assign PAUSE_SEND   = q.pause_pend & TX_ENABLE;                   // RQ15 RQ11
    assign PAUSE_TIME   = q.pause_time;                               // RQ10 RQ11
    assign BACKPRESSURE = bp_active;                                  // RQ13 RQ15
    assign TX_HALT      = (q.halt_cnt != 16'h0000);                   // RQ20
    assign RX_PASS_CTRL = q.pass_ctrl;                                // RQ17

endmodule : phy_mgmt_flow

`default_nettype wire

// File: testbench/phy_mgmt_flow_sva.sv
/* port assertions for the phy management and pause flow-control block.
   assumes a bind onto phy_mgmt_flow and the package byte addresses. */
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_flow_sva
    import phy_mgmt_pkg::*;
(
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // management link
    input wire logic        MDC,
    input wire logic        MDIO_O,
    input wire logic        MDIO_OE_N,
    // mac side
    input wire logic        TX_ENABLE,
    input wire logic        FULL_DUPLEX,
    input wire logic        PAUSE_REQ,
    input wire logic        PAUSE_SENT,
    input wire logic        BACKPRESSURE_REQ,
    input wire logic        PAUSE_SEND,
    input wire logic [15:0] PAUSE_TIME,
    input wire logic        BACKPRESSURE,
    input wire logic        RX_PAUSE_VALID,
    input wire logic        TX_HALT
);
    logic [7:0] hi_q;
    logic       wf;
    logic       mapped;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // flow write commit and mapped address decode
    assign wf     = PSEL && PENABLE && PREADY && PWRITE && (PADDR == ADDR_FLOW);
    assign mapped = PADDR inside {ADDR_ACCESS, ADDR_DATA, ADDR_FLOW};
    // length of the current mdc high phase
    always_ff @(posedge REF_CLK or negedge RST_N)
        if (!RST_N)
            hi_q <= 8'h00;
        else
            hi_q <= MDC ? hi_q + 8'h01 : 8'h00;
    property p_apb_wait;
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb wait state wrong");
    property p_unmapped;
        PREADY && !mapped |-> PSLVERR && (PWRITE || PRDATA == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access");
    property p_resv;
        PREADY && !PWRITE && mapped |-> (PADDR == ADDR_FLOW) ? PRDATA[15:3] == 13'h0
            : PRDATA[31:16] == 16'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    property p_pt;
        $changed(PAUSE_TIME) |-> $past(wf) || $past(wf, 2);
    endproperty
    a_pt: assert property (p_pt) else $error("pause time moved alone");
    property p_no_tx;
        !TX_ENABLE |-> !PAUSE_SEND && !BACKPRESSURE;
    endproperty
    a_no_tx: assert property (p_no_tx) else $error("sending while disabled");
    property p_bp;
        BACKPRESSURE == (BACKPRESSURE_REQ && TX_ENABLE && !FULL_DUPLEX);
    endproperty
    a_bp: assert property (p_bp) else $error("back pressure wrong");
    property p_pause_req;
        PAUSE_REQ && FULL_DUPLEX && TX_ENABLE ##1 TX_ENABLE |-> PAUSE_SEND;
    endproperty
    a_pause_req: assert property (p_pause_req) else $error("pause not pending");
    property p_pause_hold;
        PAUSE_SEND && !PAUSE_SENT ##1 TX_ENABLE |-> PAUSE_SEND;
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause dropped");
    property p_mdc_half;
        $fell(MDC) |-> hi_q == MDC_HALF_CYC;
    endproperty
    a_mdc_half: assert property (p_mdc_half) else $error("mdc high phase");
    property p_mdio_edge;
        $changed(MDIO_O) && !MDIO_OE_N && !$past(MDIO_OE_N) |-> $fell(MDC);
    endproperty
    a_mdio_edge: assert property (p_mdio_edge) else $error("mdio moved off edge");
    property p_halt;
        $rose(TX_HALT) |-> $past(RX_PAUSE_VALID);
    endproperty
    a_halt: assert property (p_halt) else $error("halt without pause");
endmodule : phy_mgmt_flow_sva
`default_nettype wire

// File: testbench/mdio_phy_model.sv
/* behavioural phy on the management link: records each frame and
   answers reads at its own address; the shared line has a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module mdio_phy_model #(
    parameter logic [4:0]  ADDR   = 5'h01,
    parameter logic [15:0] RD_VAL = 16'h5a3c
) (
    // management link
    input  wire logic        MDC,
    input  wire logic        MDIO_O,
    input  wire logic        MDIO_OE_N,
    output logic             MDIO_I,
    // last frame seen, first bit highest
    output logic [63:0]      frame
);
    logic [6:0] cnt;
    logic       drv;
    logic       dq;
    // wire level, released line pulled high
    assign MDIO_I = !MDIO_OE_N ? MDIO_O : (drv ? dq : 1'b1);
    initial
    begin
        cnt   = 7'h00;
        drv   = 1'b0;
        dq    = 1'b1;
        frame = 64'h0;
    end
    // frame restarts when the device takes the line
    always @(negedge MDIO_OE_N)
        cnt = 7'h00;
    // capture on rise, answer after it
    always @(posedge MDC)
    begin
        frame = {frame[62:0], MDIO_I};
        cnt   = cnt + 7'h01;
        if (cnt == 7'h2f)
        begin
            drv = frame[12:11] == 2'h2 && frame[10:6] == ADDR;
            dq  = 1'b0;
        end
        else if (cnt < 7'h40 && cnt > 7'h2f)
            dq = RD_VAL[7'h3f - cnt];
        else
            drv = 1'b0;
    end
endmodule : mdio_phy_model
`default_nettype wire

// File: testbench/phy_mgmt_flow_bench.sv
/* self-checking bench: apb register accesses, management frames to a phy
   model, pause and back-pressure strobes. assumes a 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_flow_bench;
    import phy_mgmt_pkg::*;
    logic        REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        MDC, MDIO_O, MDIO_OE_N, MDIO_I, TX_ENABLE, FULL_DUPLEX;
    logic        PAUSE_REQ, PAUSE_SENT, BACKPRESSURE_REQ, PAUSE_SEND, BACKPRESSURE;
    logic        RX_PAUSE_VALID, SLOT_TICK, TX_HALT, RX_PASS_CTRL, e;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, r;
    logic [15:0] PAUSE_TIME, RX_PAUSE_QUANTA;
    logic [63:0] frame;
    int          errors, checks_done, i;
    phy_mgmt_flow i_phy_mgmt_flow (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MDC(MDC),
        .MDIO_O(MDIO_O), .MDIO_OE_N(MDIO_OE_N), .MDIO_I(MDIO_I), .TX_ENABLE(TX_ENABLE),
        .FULL_DUPLEX(FULL_DUPLEX), .PAUSE_REQ(PAUSE_REQ), .PAUSE_SENT(PAUSE_SENT),
        .BACKPRESSURE_REQ(BACKPRESSURE_REQ), .PAUSE_SEND(PAUSE_SEND),
        .PAUSE_TIME(PAUSE_TIME), .BACKPRESSURE(BACKPRESSURE),
        .RX_PAUSE_VALID(RX_PAUSE_VALID), .RX_PAUSE_QUANTA(RX_PAUSE_QUANTA),
        .SLOT_TICK(SLOT_TICK), .TX_HALT(TX_HALT), .RX_PASS_CTRL(RX_PASS_CTRL));
    mdio_phy_model i_mdio_phy_model (.MDC(MDC), .MDIO_O(MDIO_O),
        .MDIO_OE_N(MDIO_OE_N), .MDIO_I(MDIO_I), .frame(frame));
    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // one comparison
    task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
        checks_done++;
        if (g !== x)
        begin
            errors++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge REF_CLK);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge REF_CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        r = PRDATA;
        e = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 20)
        begin
            errors++;
            report_and_stop();
        end
    endtask : xfer
    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(n, x, r);
    endtask : rd_chk
    // poll the access busy bit, bounded
    task automatic wait_idle;
        int n;
        n = 0;
        do
        begin
            xfer(1'b0, ADDR_ACCESS, 32'h0);
            n++;
        end
        while (r[0] !== 1'b0 && n < 2000);
        chk("idle", 64'h0, r[0]);
        if (r[0] !== 1'b0)
            report_and_stop();
    endtask : wait_idle
    // phy read with a refused data write while busy
    task automatic mrd(input logic [4:0] p, input logic [4:0] x, input logic [31:0] v);
        xfer(1'b1, ADDR_ACCESS, {16'h0, p, x, 6'h01});
        xfer(1'b1, ADDR_DATA, 32'h0000_0000);
        wait_idle();
        rd_chk("mrd", ADDR_DATA, v);
    endtask : mrd
    // one-cycle strobe: 0 pause req, 1 pause sent, 2 rx pause, 3 slot tick
    task automatic pulse(input int k);
        @(posedge REF_CLK);
        {PAUSE_REQ, PAUSE_SENT, RX_PAUSE_VALID, SLOT_TICK} <= 4'h8 >> k;
        @(posedge REF_CLK);
        {PAUSE_REQ, PAUSE_SENT, RX_PAUSE_VALID, SLOT_TICK} <= 4'h0;
        @(negedge REF_CLK);
    endtask : pulse
    initial
    begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    initial
    begin
        {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {PAUSE_REQ, PAUSE_SENT, BACKPRESSURE_REQ, RX_PAUSE_VALID, SLOT_TICK} = '0;
        {TX_ENABLE, FULL_DUPLEX, RX_PAUSE_QUANTA} = {2'h3, 16'h0003};
        {errors, checks_done} = '0;
        repeat (2) @(posedge REF_CLK);
        RST_N <= 1'b1;
        rd_chk("acc_rst", ADDR_ACCESS, ACCESS_RESET);
        rd_chk("dat_rst", ADDR_DATA, DATA_RESET);
        rd_chk("flw_rst", ADDR_FLOW, FLOW_RESET);
        xfer(1'b0, 12'h024, 32'h0);
        chk("slverr", 64'h1, e);
        xfer(1'b1, ADDR_DATA, 32'h1234_abcd);
        rd_chk("dat_w", ADDR_DATA, 32'h0000_abcd);
        xfer(1'b1, ADDR_ACCESS, 32'hffff_0abf);
        rd_chk("acc_busy", ADDR_ACCESS, 32'h0000_0a83);
        wait_idle();
        chk("wr_frame", {32'hffff_ffff, 4'h5, 5'h01, 5'h0a, 2'h2, 16'habcd}, frame);
        mrd(5'h01, 5'h03, 32'h0000_5a3c);
        mrd(5'h02, 5'h03, 32'h0000_ffff);
        xfer(1'b1, ADDR_FLOW, 32'hbeef_0006);
        rd_chk("flow", ADDR_FLOW, 32'hbeef_0006);
        chk("ptime", 64'hbeef, PAUSE_TIME);
        chk("pass", 64'h1, RX_PASS_CTRL);
        pulse(0);
        chk("send", 64'h1, PAUSE_SEND);
        rd_chk("fbusy", ADDR_FLOW, 32'hbeef_0007);
        pulse(1);
        rd_chk("fdone", ADDR_FLOW, 32'hbeef_0006);
        pulse(0);
        @(posedge REF_CLK);
        TX_ENABLE <= 1'b0;
        BACKPRESSURE_REQ <= 1'b1;
        FULL_DUPLEX <= 1'b0;
        @(negedge REF_CLK);
        chk("off", 64'h0, {PAUSE_SEND, BACKPRESSURE});
        rd_chk("dropped", ADDR_FLOW, 32'hbeef_0006);
        TX_ENABLE <= 1'b1;
        @(negedge REF_CLK);
        chk("bp", 64'h1, BACKPRESSURE);
        rd_chk("bpbusy", ADDR_FLOW, 32'hbeef_0007);
        {FULL_DUPLEX, BACKPRESSURE_REQ} <= 2'h2;
        pulse(2);
        @(negedge REF_CLK);
        for (i = 1; i <= 3; i++)
        begin
            chk("halt", 64'h1, TX_HALT);
            pulse(3);
            @(negedge REF_CLK);
        end
        chk("halt_end", 64'h0, TX_HALT);
        rd_chk("fidle", ADDR_FLOW, 32'hbeef_0006);
        xfer(1'b1, ADDR_FLOW, 32'hbeef_0000);
        pulse(2);
        @(negedge REF_CLK);
        chk("rx_off", 64'h0, TX_HALT);
        report_and_stop();
    end
endmodule : phy_mgmt_flow_bench
bind phy_mgmt_flow phy_mgmt_flow_sva i_phy_mgmt_flow_sva (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .MDC(MDC), .MDIO_O(MDIO_O), .MDIO_OE_N(MDIO_OE_N),
    .TX_ENABLE(TX_ENABLE), .FULL_DUPLEX(FULL_DUPLEX), .PAUSE_REQ(PAUSE_REQ),
    .PAUSE_SENT(PAUSE_SENT), .BACKPRESSURE_REQ(BACKPRESSURE_REQ), .PAUSE_SEND(PAUSE_SEND),
    .PAUSE_TIME(PAUSE_TIME), .BACKPRESSURE(BACKPRESSURE),
    .RX_PAUSE_VALID(RX_PAUSE_VALID), .TX_HALT(TX_HALT));
`default_nettype wire
